//--- hdl/fifo_host_ctl.sv
// ahb-lite controller driving a strobe fifo (or width/depth group) through its pins
`timescale 1ns/1ns
`default_nettype none
module fifo_host_ctl #(
  parameter int data_w = 9,
  parameter int chain_n = 2
) (
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic      [31:0]                    hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  output fifo_ctl_pkg::fifo_ctl_pins_t        pins,
  output logic      [data_w-1:0]              fifo_d,
  input  wire logic [data_w-1:0]              fifo_q,
  input  wire fifo_ctl_pkg::fifo_flag_pins_t [chain_n-1:0] flags
);
  // ------------------------------------------------------------
  // composite flags
  // ------------------------------------------------------------
  logic [chain_n-1:0] ef_v;
  logic [chain_n-1:0] ff_v;
  for (genvar g = 0; g < chain_n; g++) begin : g_flag
    assign ef_v[g] = flags[g].empty_flag_n;
    assign ff_v[g] = flags[g].full_flag_n;
  end
  logic depth_q;
  logic first_q;
  logic any_empty_n;
  logic any_full_n;
  logic empty_n;
  logic full_n;
  logic half_low;
  // single/width mode: flags of part 0 stand for the group
  assign any_empty_n = depth_q ? (|ef_v) : ef_v[0];
  assign any_full_n  = depth_q ? (|ff_v) : ff_v[0];
  assign empty_n     = any_empty_n;
  assign full_n      = any_full_n;
  assign half_low    = !depth_q && !flags[0].half_level_flag_n;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic        ph_q;
  logic        ph_wr_q;
  logic [7:0]  ph_a_q;
  logic        take;
  fifo_ctl_pkg::seq_state_t st_q;
  logic        busy;
  logic        rvld_q;
  logic        drop_q;
  logic        inited_q;
  logic [data_w-1:0] rbuf_q;
  logic [11:0] level_q;
  logic [8:0]  cnt_q;
  logic        go_rst;
  logic        go_wr;
  logic        go_rd;
  logic        go_rew;
  assign busy = (st_q != fifo_ctl_pkg::st_idle);
  assign take = hsel && hready && htrans[1];
  // transfers that may run a pin cycle; a refused one ends after one wait state
  logic active;
  logic seq_end;
  logic act;
  assign active  = hwrite ? (haddr[7:0] == fifo_ctl_pkg::ctrl_off ||
                             haddr[7:0] == fifo_ctl_pkg::wdata_off) :
                            (haddr[7:0] == fifo_ctl_pkg::rdata_off);
  // the waiting data phase owns the sequence, so its end releases hready
  assign seq_end = (st_q == fifo_ctl_pkg::st_rec) &&
                   (cnt_q == 9'(fifo_ctl_pkg::recov_cyc - 1));

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q    <= 1'b0;
      ph_wr_q <= 1'b0;
      ph_a_q  <= 8'h00;
    end else if (hreadyout) begin
      ph_q    <= take;
      ph_wr_q <= hwrite;
      ph_a_q  <= haddr[7:0];
    end
  end

  // hready and response, registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      // holding the bus through the pin cycle keeps a second command from being lost
      if (hreadyout) begin
        hreadyout <= !(take && active);
      end else begin
        hreadyout <= (act && !(go_rst || go_wr || go_rd || go_rew)) || seq_end;
      end
      hresp     <= 1'b0;
    end
  end

  // commands decoded in data phase once idle
  assign act = ph_q && !hreadyout && !busy;
  assign go_rst = act && ph_wr_q && ph_a_q == fifo_ctl_pkg::ctrl_off &&
                  hwdata[fifo_ctl_pkg::ctrl_reset_bit];
  assign go_rew = act && ph_wr_q && ph_a_q == fifo_ctl_pkg::ctrl_off && !go_rst &&
                  hwdata[fifo_ctl_pkg::ctrl_rewind_bit] && !depth_q;
  // write only when full inactive and after reset
  assign go_wr  = act && ph_wr_q && ph_a_q == fifo_ctl_pkg::wdata_off && full_n && inited_q;
  assign go_rd  = act && !ph_wr_q && ph_a_q == fifo_ctl_pkg::rdata_off && empty_n;

  // read data mux
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && hreadyout && !hwrite) begin
      if (haddr[7:0] == fifo_ctl_pkg::ctrl_off) begin
        hrdata <= {29'h0, first_q, depth_q, 1'b0};
      end else if (haddr[7:0] == fifo_ctl_pkg::status_off) begin
        hrdata <= {26'h0, drop_q, rvld_q, half_low, !full_n, !empty_n, busy};
      end else if (haddr[7:0] == fifo_ctl_pkg::level_off) begin
        hrdata <= {20'h0, level_q};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end else if (ph_q && !ph_wr_q && ph_a_q == fifo_ctl_pkg::rdata_off && st_q == fifo_ctl_pkg::st_rec) begin
      hrdata <= {{(32-data_w){1'b0}}, rbuf_q};
    end else if (ph_q && !ph_wr_q && ph_a_q == fifo_ctl_pkg::rdata_off && act && !empty_n) begin
      hrdata <= 32'h0000_0000; // empty: read answers zero
    end
  end

  // mode bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      depth_q <= 1'b0;
      first_q <= 1'b1;
    end else if (act && ph_wr_q && ph_a_q == fifo_ctl_pkg::ctrl_off) begin
      depth_q <= hwdata[fifo_ctl_pkg::ctrl_depth_bit];
      first_q <= hwdata[fifo_ctl_pkg::ctrl_first_bit];
    end
  end

  // ------------------------------------------------------------
  // pin sequencer
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q  <= fifo_ctl_pkg::st_idle;
      cnt_q <= 9'h000;
      pins  <= '{write_n: 1'b1, read_n: 1'b1, reset_n: 1'b1,
                 first_load_n: 1'b1, expansion_in_n: 1'b1};
      fifo_d <= '0;
      rbuf_q <= '0;
    end else begin
      case (st_q)
        fifo_ctl_pkg::st_idle: begin
          cnt_q <= 9'h000;
          if (go_rst) begin
            st_q <= fifo_ctl_pkg::st_rst;
            pins.reset_n <= 1'b0;
            pins.expansion_in_n <= hwdata[fifo_ctl_pkg::ctrl_depth_bit];
            // first part of a depth chain low during reset; other parts and single/width mode high
            pins.first_load_n <= !(hwdata[fifo_ctl_pkg::ctrl_depth_bit] &&
                                   hwdata[fifo_ctl_pkg::ctrl_first_bit]);
          end else if (go_wr) begin
            st_q <= fifo_ctl_pkg::st_wr;
            fifo_d <= hwdata[data_w-1:0];
            pins.write_n <= 1'b0;
          end else if (go_rd) begin
            st_q <= fifo_ctl_pkg::st_rd;
            pins.read_n <= 1'b0;
          end else if (go_rew) begin
            st_q <= fifo_ctl_pkg::st_rew;
            pins.first_load_n <= 1'b0;
          end
        end
        fifo_ctl_pkg::st_rst: begin
          cnt_q <= cnt_q + 9'd1;
          if (cnt_q == 9'(fifo_ctl_pkg::rst_cyc - 1)) begin
            pins.reset_n <= 1'b1;
            st_q <= fifo_ctl_pkg::st_rec;
            cnt_q <= 9'h000;
          end
        end
        fifo_ctl_pkg::st_wr, fifo_ctl_pkg::st_rd, fifo_ctl_pkg::st_rew: begin
          cnt_q <= cnt_q + 9'd1;
          if (cnt_q == 9'(fifo_ctl_pkg::acc_cyc - 1) && st_q == fifo_ctl_pkg::st_rd) begin
            rbuf_q <= fifo_q;
          end
          if (cnt_q == 9'(fifo_ctl_pkg::strobe_cyc - 1)) begin
            pins.write_n <= 1'b1;
            pins.read_n  <= 1'b1;
            pins.first_load_n <= depth_q ? !first_q : 1'b1;
            st_q  <= fifo_ctl_pkg::st_rec;
            cnt_q <= 9'h000;
          end
        end
        fifo_ctl_pkg::st_rec: begin
          cnt_q <= cnt_q + 9'd1;
          if (cnt_q == 9'(fifo_ctl_pkg::recov_cyc - 1)) begin
            pins.expansion_in_n <= 1'b1;
            st_q <= fifo_ctl_pkg::st_idle;
          end
        end
        default: st_q <= fifo_ctl_pkg::st_idle;
      endcase
    end
  end

  // status bookkeeping; a new drop wins over the clear by reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inited_q <= 1'b0;
      drop_q   <= 1'b0;
      rvld_q   <= 1'b0;
      level_q  <= 12'h000;
    end else begin
      if (go_rst) begin
        inited_q <= 1'b1;
        level_q  <= 12'h000;
        rvld_q   <= 1'b0;
      end else if (go_wr) begin
        level_q <= level_q + 12'd1;
      end else if (go_rd) begin
        level_q <= level_q - 12'd1;
        rvld_q  <= 1'b1;
      end
      if (act && ph_wr_q && ph_a_q == fifo_ctl_pkg::wdata_off && !(full_n && inited_q)) begin
        drop_q <= 1'b1;
      end else if (go_rst) begin
        drop_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/fifo_ctl_pkg.sv
// package: register map, pin carriers, timing counts for the strobe fifo controller
package fifo_ctl_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] wdata_off  = 8'h04;
  localparam logic [7:0] rdata_off  = 8'h08;
  localparam logic [7:0] status_off = 8'h0c;
  localparam logic [7:0] level_off  = 8'h10;
  // ctrl fields
  localparam int ctrl_reset_bit  = 0;  // write 1: run a reset cycle
  localparam int ctrl_depth_bit  = 1;  // depth-chain mode
  localparam int ctrl_first_bit  = 2;  // this part is first in chain
  localparam int ctrl_rewind_bit = 3;  // write 1: rewind pulse, single/width mode only; reset bit wins
  // status fields
  localparam int st_busy_bit  = 0;
  localparam int st_empty_bit = 1;
  localparam int st_full_bit  = 2;
  localparam int st_half_bit  = 3;
  localparam int st_rvld_bit  = 4;
  localparam int st_drop_bit  = 5;
  // ------------------------------------------------------------
  // device figures and timing
  // ------------------------------------------------------------
  localparam int depth_words = 2048;
  localparam int clk_mhz     = 50;
  localparam int clk_ns      = 1000 / clk_mhz;
  localparam int strobe_ns   = 200;  // pulse width, slowest grade
  localparam int recov_ns    = 35;
  localparam int rst_setup_ns = 180;
  localparam int acc_ns      = 200;
  localparam int strobe_cyc  = (strobe_ns + clk_ns - 1) / clk_ns;
  localparam int recov_cyc   = (recov_ns + clk_ns - 1) / clk_ns;
  localparam int rst_cyc     = (rst_setup_ns + strobe_ns + clk_ns - 1) / clk_ns;
  localparam int acc_cyc     = (acc_ns + clk_ns - 1) / clk_ns;
  // ------------------------------------------------------------
  // pin carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic write_n;
    logic read_n;
    logic reset_n;
    logic first_load_n;   // doubles as rewind_pulse_n outside reset in single/width mode
    logic expansion_in_n; // held low at reset for single mode
  } fifo_ctl_pins_t;
  typedef struct packed {
    logic empty_flag_n;
    logic full_flag_n;
    logic half_level_flag_n;
  } fifo_flag_pins_t;
  typedef enum logic [5:0] {
    st_idle  = 6'b000001,
    st_rst   = 6'b000010,
    st_wr    = 6'b000100,
    st_rd    = 6'b001000,
    st_rew   = 6'b010000,
    st_rec   = 6'b100000
  } seq_state_t;
endpackage

//--- testbench/fifo_host_ctl_monitor.sv
// checker: pin sequencing and bus answers of the fifo host controller
`timescale 1ns/1ns
`default_nettype none
module fifo_host_ctl_monitor #(
  parameter int data_w  = 9,
  parameter int chain_n = 2
) (
  input wire logic                                          hclk,
  input wire logic                                          hresetn,
  input wire logic                                          hsel,
  input wire logic [31:0]                                   haddr,
  input wire logic [1:0]                                    htrans,
  input wire logic                                          hwrite,
  input wire logic [2:0]                                    hsize,
  input wire logic [31:0]                                   hwdata,
  input wire logic                                          hready,
  input wire logic [31:0]                                   hrdata,
  input wire logic                                          hreadyout,
  input wire logic                                          hresp,
  input wire fifo_ctl_pkg::fifo_ctl_pins_t                  pins,
  input wire logic [data_w-1:0]                             fifo_d,
  input wire logic [data_w-1:0]                             fifo_q,
  input wire fifo_ctl_pkg::fifo_flag_pins_t [chain_n-1:0]   flags
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  // flags are taken from part 0; a wider chain would need the composite
  a_write_not_full: assert property (
    $fell(pins.write_n) |-> $past(flags[0].full_flag_n)) else $error("write strobe while full");
  a_read_not_empty: assert property (
    $fell(pins.read_n) |-> $past(flags[0].empty_flag_n)) else $error("read strobe while empty");
  a_write_width: assert property (
    $fell(pins.write_n) |-> !pins.write_n [*8]) else $error("write strobe too short");
  a_read_width: assert property (
    $fell(pins.read_n) |-> !pins.read_n [*8]) else $error("read strobe too short");
  a_strobe_recov: assert property (
    $rose(pins.write_n) || $rose(pins.read_n) |-> (pins.write_n && pins.read_n) [*2])
    else $error("strobe recovery too short");
  a_reset_quiet: assert property (
    !pins.reset_n |-> pins.write_n && pins.read_n) else $error("strobe during reset");
  a_reset_width: assert property (
    $fell(pins.reset_n) |-> !pins.reset_n [*8]) else $error("reset pulse too short");
  a_data_held: assert property (
    !pins.write_n && !$fell(pins.write_n) |-> $stable(fifo_d)) else $error("data moved");
  a_stall_bound: assert property (
    !hreadyout |-> ##[1:60] hreadyout) else $error("wait state too long");
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
  c_write: cover property ($fell(pins.write_n));
  c_read: cover property ($fell(pins.read_n));
  c_reset: cover property ($fell(pins.reset_n));
endmodule
bind fifo_host_ctl fifo_host_ctl_monitor #(.data_w(data_w), .chain_n(chain_n))
  i_fifo_host_ctl_monitor (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pins, .fifo_d, .fifo_q, .flags);
`default_nettype wire

//--- testbench/fifo_dev_model.sv
// behavioural model of one strobe fifo part on the controller pins
`timescale 1ns/1ns
`default_nettype none
module fifo_dev_model #(
  parameter int words  = 2048,
  parameter int data_w = 9
) (
  input  wire fifo_ctl_pkg::fifo_ctl_pins_t pins,
  input  wire logic [data_w-1:0]            d,
  output logic      [data_w-1:0]            q,
  output fifo_ctl_pkg::fifo_flag_pins_t     flags
);
  logic [data_w-1:0] mem [words];
  int   wp = 0, rp = 0, cnt = 0, xi_n = 0;
  logic depth_q = 1'b0, first_q = 1'b1, wok = 1'b0, rok = 1'b0;
  initial q = '0;
  // ------------------------------------------------------------
  // pointers, mode and strobes
  // ------------------------------------------------------------
  always @(negedge pins.reset_n) begin
    wp = 0;
    rp = 0;
    cnt = 0;
    xi_n = 0;
  end
  // mode is latched as reset ends
  always @(posedge pins.reset_n) begin
    depth_q = pins.expansion_in_n;
    first_q = !pins.first_load_n;
  end
  always @(negedge pins.expansion_in_n) if (pins.reset_n) xi_n++;
  // counted at the falling edge so full and half move with the write
  always @(negedge pins.write_n) begin
    wok = pins.reset_n && cnt < words && (!depth_q || first_q || xi_n > 0);
    if (wok) cnt++;
  end
  always @(posedge pins.write_n) if (wok) begin
    mem[wp] = d;
    wp = (wp + 1) % words;
  end
  // rewind moves only the read side back to the first location
  always @(negedge pins.first_load_n) if (pins.reset_n && !depth_q) begin
    rp = 0;
    cnt = wp;
  end
  always @(negedge pins.read_n) begin
    rok = pins.reset_n && cnt > 0 && (!depth_q || first_q || xi_n > 1);
    if (rok) q = mem[rp];
  end
  // released data shows the inverse, so a late sample cannot match by luck
  always @(posedge pins.read_n) begin
    q = ~q;
    if (rok) begin
      rp = (rp + 1) % words;
      cnt--;
    end
  end
  assign flags = {cnt != 0, cnt != words, depth_q || cnt <= words / 2};
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench: controller and fifo model, driven over ahb-lite
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int dw = 9;
  logic                               hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0]                        haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]                         htrans = 2'b00;
  logic [2:0]                         hsize = 3'b010;
  logic                               hreadyout, hresp;
  fifo_ctl_pkg::fifo_ctl_pins_t       pins;
  fifo_ctl_pkg::fifo_flag_pins_t [0:0] flags;
  logic [dw-1:0]                      fifo_d, fifo_q;
  int                                 errors = 0, n_compared = 0;
  always #10 hclk = ~hclk;
  fifo_host_ctl #(.data_w(dw), .chain_n(1)) i_fifo_host_ctl (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pins(pins), .fifo_d(fifo_d), .fifo_q(fifo_q), .flags(flags));
  // small depth keeps full and half reachable in a few writes
  fifo_dev_model #(.words(8), .data_w(dw)) i_fifo_dev_model (.pins(pins), .d(fifo_d),
    .q(fifo_q), .flags(flags[0]));
  // ------------------------------------------------------------
  // bus tasks and checks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one single transfer; waits are bounded, a stuck slave ends the run
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 200);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 200);
    rd = hrdata;
    if (n >= 200) begin
      errors++;
      $display("FAIL %0t bus timeout", $time);
      summarize();
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic status(input logic [31:0] exp);
    bus(1'b0, fifo_ctl_pkg::status_off, 32'h0);
    chk(rd & 32'h3e, exp);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({27'h0, pins}, 32'h1f);
    bus(1'b1, fifo_ctl_pkg::wdata_off, 32'h155);
    status(32'h22);
    bus(1'b1, fifo_ctl_pkg::ctrl_off, 32'h1);
    status(32'h02);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, fifo_ctl_pkg::wdata_off, 32'h23 * i + 32'h7);
      status({28'h0, i >= 4, i == 7, 2'b00});
    end
    bus(1'b1, fifo_ctl_pkg::wdata_off, 32'h1ff);
    status(32'h2c);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, fifo_ctl_pkg::rdata_off, 32'h0);
      chk(rd & 32'h1ff, 32'h23 * i + 32'h7);
      status({26'h0, 1'b1, 1'b1, i < 3, 1'b0, i == 7, 1'b0});
    end
    bus(1'b0, fifo_ctl_pkg::rdata_off, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    // depth mode, first part: half flag ignored, strobes accepted at once
    bus(1'b1, fifo_ctl_pkg::ctrl_off, 32'h7);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, fifo_ctl_pkg::wdata_off, 32'h40 + i);
      status(32'h0);
    end
    bus(1'b0, fifo_ctl_pkg::level_off, 32'h0);
    chk(rd, 32'h6);
    bus(1'b0, fifo_ctl_pkg::ctrl_off, 32'h0);
    chk(rd, 32'h6);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, fifo_ctl_pkg::rdata_off, 32'h0);
      chk(rd & 32'h1ff, 32'h40 + i);
    end
    // single mode again: a rewind replays from the first stored word
    bus(1'b1, fifo_ctl_pkg::ctrl_off, 32'h1);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, fifo_ctl_pkg::wdata_off, 32'h60 + i);
    end
    bus(1'b0, fifo_ctl_pkg::rdata_off, 32'h0);
    bus(1'b0, fifo_ctl_pkg::rdata_off, 32'h0);
    chk(rd & 32'h1ff, 32'h61);
    bus(1'b1, fifo_ctl_pkg::ctrl_off, 32'h8);
    bus(1'b0, fifo_ctl_pkg::rdata_off, 32'h0);
    chk(rd & 32'h1ff, 32'h60);
    summarize();
  end
endmodule
`default_nettype wire
